/* src/gsi_params.svh */
// register offsets, field positions and reset values of the interrupt logic
`ifndef GSI_PARAMS_SVH
`define GSI_PARAMS_SVH

`define GSI_OFF_P0_IEN      12'h004
`define GSI_OFF_P1_IEN      12'h005
`define GSI_OFF_POL0        12'h008
`define GSI_OFF_POL1        12'h009
`define GSI_OFF_GIEN        12'h020
`define GSI_OFF_PEND        12'h040
`define GSI_OFF_VECT        12'h044
`define GSI_OFF_ACK         12'h048
`define GSI_OFF_PINS        12'h04C
`define GSI_IEN_RESET       8'h00
`define GSI_GIEN_RESET      8'h00
`define GSI_GIEN_MASK       8'hDE
`define GSI_BIT_T128        1
`define GSI_BIT_T1024       2
`define GSI_BIT_EP0         3
`define GSI_BIT_EP1         4
`define GSI_BIT_GPIO        6
`define GSI_BIT_WAKE        7
`define GSI_LVL_GPIO        6
`define GSI_LVL_WAKE        7
`define GSI_RESP_OKAY       2'b00
`define GSI_RESP_SLVERR     2'b10

`endif

/* src/gsi_pkg.sv */
// types of the interrupt logic
package gsi_pkg;
    typedef enum logic [1:0] {GSI_IDLE, GSI_CLR_PEND, GSI_CALL} gsi_ack_t;
    typedef logic [7:0] gsi_byte_t;
endpackage

/* src/gsi_irq_ctrl.sv */
// gpio and source interrupt logic with priority encoder and axi4-lite slave
// ----------------------------------------------------------------
// Functional notes
// - polarity bit one selects rising edge trigger, zero selects falling edge
// - each pin interrupt is gated by its own enable bit
// - pin enable registers at 0x04 and 0x05, write only, reset to zero
// - OR of enabled pin detections; its rising edge sets the gpio flip-flop
// - gpio flip-flop is gated by global gpio enable before the encoder
// - gpio acknowledge clears gpio flip-flop and global gpio enable
// - no new gpio event until the OR output falls again
// - clearing and resetting an enable on an active pin gives a new event
// - no priority among pins; pin enables unchanged by acknowledge
// - eight fixed levels, vectors two bytes apart, zero highest
// - endpoint 0 event raises interrupt, masked by global bit 3
// - endpoint 1 acknowledged transmit raises interrupt, masked by bit 4
// - timer interrupts masked by global bits 1 and 2
// - rising wake pin latches wake-up interrupt, masked by bit 7
// - each source held pending until serviced or reset; enabled ones request
// - service clears global enables, then pending latch, then calls vector
// - global enable register at 0x20, one enables, resets to zero
// - pending sampled at instruction end; highest enabled request serviced
// ----------------------------------------------------------------
//
// Design decision made here: register access over AXI4-Lite.
`include "gsi_params.svh"

module gsi_irq_ctrl
(
    // clock and reset
    input  wire logic        mclk,
    input  wire logic        reset_n,
    // axi4-lite write address
    input  wire logic [11:0] s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // axi4-lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // axi4-lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // axi4-lite read address
    input  wire logic [11:0] s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // axi4-lite read data
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // port pins
    input  wire logic [7:0]  port0Pins,
    input  wire logic [7:0]  port1Pins,
    input  wire logic        wakePin,
    // source events from timers and usb engine
    input  wire logic        timer128Event,
    input  wire logic        timer1024Event,
    input  wire logic        ep0RxAccepted,
    input  wire logic        ep0TxAcked,
    input  wire logic        ep1TxAcked,
    // core side
    input  wire logic        instrLastClk,
    output logic             irqValid,
    output logic [7:0]       irqVector,
    output logic             callStrobe,
    output logic [7:0]       callVector
);

    // ----------------------------------------------------------------
    // functions
    // ----------------------------------------------------------------
    function automatic logic [7:0] pinDetect(input logic [7:0] pins, input logic [7:0] pol);
        pinDetect = ~(pins ^ pol);
    endfunction

    function automatic logic [7:0] byteLane(input logic [31:0] d, input logic [3:0] s, input logic [7:0] old);
        byteLane = s[0] ? d[7:0] : old;
    endfunction

    // register index to byte address, one aligned word per register
    function automatic logic [11:0] regAddr(input logic [11:0] idx);
        regAddr = {idx[9:0], 2'b00};
    endfunction

    // ----------------------------------------------------------------
    // input synchronisers
    // ----------------------------------------------------------------
    logic [16:0] syncA;
    logic [16:0] syncB;

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            syncA <= 17'h0_0000;
            syncB <= 17'h0_0000;
        end
        else
        begin
            syncA <= {wakePin, port1Pins, port0Pins};
            syncB <= syncA;
        end
    end

    // ----------------------------------------------------------------
    // registers
    // ----------------------------------------------------------------
    gsi_pkg::gsi_byte_t port0_pin_irq_enable;
    gsi_pkg::gsi_byte_t port1_pin_irq_enable;
    gsi_pkg::gsi_byte_t polarity0;
    gsi_pkg::gsi_byte_t polarity1;
    gsi_pkg::gsi_byte_t globalEnable;
    logic [7:0]         pending;
    logic               gpioOrPrev;
    logic               wakePrev;
    gsi_pkg::gsi_ack_t  ackState;
    logic [2:0]         ackLevel;
    logic               swAck;
    logic               wrFire;

    logic               awHeld;
    logic               wHeld;
    logic [11:0]        awAddr;
    logic [31:0]        wData;
    logic [3:0]         wStrb;

    // ----------------------------------------------------------------
    // gpio detection
    // ----------------------------------------------------------------
    logic [15:0] pinTrig;
    logic        gpioOr;
    logic        gpioRise;
    logic        wakeRise;

    assign pinTrig  = {pinDetect(syncB[15:8], polarity1), pinDetect(syncB[7:0], polarity0)}
                    & {port1_pin_irq_enable, port0_pin_irq_enable};
    assign gpioOr   = |pinTrig;
    assign gpioRise = gpioOr & ~gpioOrPrev;
    assign wakeRise = syncB[16] & ~wakePrev;

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            gpioOrPrev <= 1'b0;
            wakePrev   <= 1'b0;
        end
        else
        begin
            gpioOrPrev <= gpioOr;
            wakePrev   <= syncB[16];
        end
    end

    // ----------------------------------------------------------------
    // pending latches and priority encoder
    // ----------------------------------------------------------------
    logic [7:0] setEvents;
    logic [7:0] requests;
    logic [2:0] winLevel;
    logic       anyReq;

    assign setEvents = {wakeRise, gpioRise, 1'b0, ep1TxAcked, ep0RxAccepted | ep0TxAcked,
                        timer1024Event, timer128Event, 1'b0};
    assign requests  = pending & globalEnable & `GSI_GIEN_MASK;

    always_comb
    begin
        winLevel = 3'd0;
        anyReq   = 1'b0;
        for (int i = 7; i >= 0; i--)
        begin
            if (requests[i])
            begin
                winLevel = i[2:0];
                anyReq   = 1'b1;
            end
        end
    end

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            pending <= 8'h00;
        end
        else
        begin
            for (int i = 0; i < 8; i++)
            begin
                if (setEvents[i])
                begin
                    pending[i] <= 1'b1;
                end
                else if (ackState == gsi_pkg::GSI_CLR_PEND && ackLevel == i[2:0])
                begin
                    pending[i] <= 1'b0;
                end
            end
        end
    end

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            irqValid  <= 1'b0;
            irqVector <= 8'h00;
        end
        else
        begin
            irqValid  <= anyReq;
            irqVector <= {4'h0, winLevel, 1'b0};
        end
    end

    // ----------------------------------------------------------------
    // acknowledge sequence
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            ackState   <= gsi_pkg::GSI_IDLE;
            ackLevel   <= 3'd0;
            callStrobe <= 1'b0;
            callVector <= 8'h00;
        end
        else
        begin
            callStrobe <= 1'b0;
            case (ackState)
                gsi_pkg::GSI_IDLE:
                begin
                    if ((instrLastClk || swAck) && anyReq)
                    begin
                        ackLevel <= winLevel;
                        ackState <= gsi_pkg::GSI_CLR_PEND;
                    end
                end
                gsi_pkg::GSI_CLR_PEND:
                begin
                    ackState <= gsi_pkg::GSI_CALL;
                end
                gsi_pkg::GSI_CALL:
                begin
                    callStrobe <= 1'b1;
                    callVector <= {4'h0, ackLevel, 1'b0};
                    ackState   <= gsi_pkg::GSI_IDLE;
                end
                default:
                begin
                    ackState <= gsi_pkg::GSI_IDLE;
                end
            endcase
        end
    end

    // ----------------------------------------------------------------
    // axi4-lite write channel
    // ----------------------------------------------------------------
    assign wrFire = awHeld && wHeld && !s_axi_bvalid;

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            awHeld        <= 1'b0;
            wHeld         <= 1'b0;
            awAddr        <= 12'h000;
            wData         <= 32'h0000_0000;
            wStrb         <= 4'h0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= `GSI_RESP_OKAY;
        end
        else
        begin
            s_axi_awready <= !awHeld && !s_axi_awready && s_axi_awvalid;
            s_axi_wready  <= !wHeld && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready)
            begin
                awHeld <= 1'b1;
                awAddr <= s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready)
            begin
                wHeld <= 1'b1;
                wData <= s_axi_wdata;
                wStrb <= s_axi_wstrb;
            end
            if (wrFire)
            begin
                awHeld       <= 1'b0;
                wHeld        <= 1'b0;
                s_axi_bvalid <= 1'b1;
                if (awAddr == regAddr(`GSI_OFF_P0_IEN) || awAddr == regAddr(`GSI_OFF_P1_IEN)
                    || awAddr == regAddr(`GSI_OFF_POL0) || awAddr == regAddr(`GSI_OFF_POL1)
                    || awAddr == regAddr(`GSI_OFF_GIEN) || awAddr == regAddr(`GSI_OFF_ACK))
                begin
                    s_axi_bresp <= `GSI_RESP_OKAY;
                end
                else
                begin
                    s_axi_bresp <= `GSI_RESP_SLVERR;
                end
            end
            else if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // register writes
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            port0_pin_irq_enable <= `GSI_IEN_RESET;
            port1_pin_irq_enable <= `GSI_IEN_RESET;
            polarity0            <= `GSI_IEN_RESET;
            polarity1            <= `GSI_IEN_RESET;
            swAck                <= 1'b0;
        end
        else
        begin
            swAck <= wrFire && awAddr == regAddr(`GSI_OFF_ACK) && wStrb[0] && wData[0];
            if (wrFire)
            begin
                if (awAddr == regAddr(`GSI_OFF_P0_IEN))
                begin
                    port0_pin_irq_enable <= byteLane(wData, wStrb, port0_pin_irq_enable);
                end
                else if (awAddr == regAddr(`GSI_OFF_P1_IEN))
                begin
                    port1_pin_irq_enable <= byteLane(wData, wStrb, port1_pin_irq_enable);
                end
                else if (awAddr == regAddr(`GSI_OFF_POL0))
                begin
                    polarity0 <= byteLane(wData, wStrb, polarity0);
                end
                else if (awAddr == regAddr(`GSI_OFF_POL1))
                begin
                    polarity1 <= byteLane(wData, wStrb, polarity1);
                end
            end
        end
    end

    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            globalEnable <= `GSI_GIEN_RESET;
        end
        else if (ackState == gsi_pkg::GSI_IDLE && (instrLastClk || swAck) && anyReq)
        begin
            globalEnable <= 8'h00;
        end
        else if (wrFire && awAddr == regAddr(`GSI_OFF_GIEN))
        begin
            globalEnable <= byteLane(wData, wStrb, globalEnable) & `GSI_GIEN_MASK;
        end
    end

    // ----------------------------------------------------------------
    // axi4-lite read channel
    // ----------------------------------------------------------------
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= `GSI_RESP_OKAY;
        end
        else
        begin
            s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
            if (s_axi_arvalid && s_axi_arready)
            begin
                s_axi_rvalid <= 1'b1;
                s_axi_rresp  <= `GSI_RESP_OKAY;
                if (s_axi_araddr == regAddr(`GSI_OFF_GIEN))
                begin
                    s_axi_rdata <= {24'h00_0000, globalEnable};
                end
                else if (s_axi_araddr == regAddr(`GSI_OFF_PEND))
                begin
                    s_axi_rdata <= {24'h00_0000, pending};
                end
                else if (s_axi_araddr == regAddr(`GSI_OFF_VECT))
                begin
                    s_axi_rdata <= {23'h00_0000, irqValid, irqVector};
                end
                else if (s_axi_araddr == regAddr(`GSI_OFF_PINS))
                begin
                    s_axi_rdata <= {15'h0000, syncB};
                end
                else
                begin
                    s_axi_rdata <= 32'h0000_0000;
                    s_axi_rresp <= `GSI_RESP_SLVERR;
                end
            end
            else if (s_axi_rvalid && s_axi_rready)
            begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end

endmodule

/* test/gsi_irq_ctrl_sva.sv */
// port assertions of the interrupt logic
`include "gsi_params.svh"

module gsi_irq_ctrl_sva
(
    // clock and reset
    input wire logic        mclk,
    input wire logic        reset_n,
    // axi4-lite
    input wire logic [11:0] s_axi_araddr,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic [1:0]  s_axi_rresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    // core side
    input wire logic        instrLastClk,
    input wire logic        irqValid,
    input wire logic [7:0]  irqVector,
    input wire logic        callStrobe,
    input wire logic [7:0]  callVector
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!reset_n);

    chk_vec_level: assert property (irqValid |-> irqVector inside {8'h02, 8'h04, 8'h06, 8'h08, 8'h0C, 8'h0E})
        else $error("vector outside the level table");
    chk_call_cause: assert property (callStrobe |-> $past(irqValid, 2))
        else $error("call without a request");
    chk_call_vector: assert property (callStrobe |-> callVector == $past(irqVector, 2))
        else $error("call vector differs from winner");
    chk_call_pulse: assert property (callStrobe |=> !callStrobe)
        else $error("call strobe longer than one cycle");
    chk_ack_disable: assert property (instrLastClk && irqValid |-> ##2 !irqValid)
        else $error("request survives acknowledge");
    chk_wo_read: assert property (s_axi_arvalid && s_axi_arready &&
        (s_axi_araddr == 12'(`GSI_OFF_P0_IEN << 2) || s_axi_araddr == 12'(`GSI_OFF_P1_IEN << 2)) |=>
        s_axi_rvalid && s_axi_rresp == `GSI_RESP_SLVERR && s_axi_rdata == 32'h0000_0000)
        else $error("write-only enable readable");
    chk_gien_read: assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 12'(`GSI_OFF_GIEN << 2) |=>
        s_axi_rvalid && s_axi_rdata[0] == 1'b0 && s_axi_rdata[5] == 1'b0 && s_axi_rdata[31:8] == 24'h00_0000)
        else $error("reserved enable bits set");
    chk_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    chk_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
endmodule

bind gsi_irq_ctrl gsi_irq_ctrl_sva i_sva
(
    .mclk, .reset_n, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .instrLastClk,
    .irqValid, .irqVector, .callStrobe, .callVector
);

/* test/gsi_core_model.sv */
// core model: ends instructions and takes interrupt calls
module gsi_core_model
(
    // clock and reset
    input  wire logic       mclk,
    input  wire logic       reset_n,
    // instruction timing, zero halts the core
    input  wire logic [3:0] instrLen,
    output logic            instrLastClk,
    // calls
    input  wire logic       callStrobe,
    input  wire logic [7:0] callVector,
    output logic [7:0]      lastCall,
    output int              callCount
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] cyc;

    // last clock of each instruction
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            cyc <= 4'h0;
            instrLastClk <= 1'b0;
        end
        else
        begin
            cyc <= (cyc + 4'h1 >= instrLen) ? 4'h0 : cyc + 4'h1;
            instrLastClk <= (instrLen != 4'h0) && (cyc + 4'h1 >= instrLen);
        end
    end

    // vector call taken by the core
    always_ff @(posedge mclk or negedge reset_n)
    begin
        if (!reset_n)
        begin
            lastCall <= 8'h00;
            callCount <= 0;
        end
        else if (callStrobe)
        begin
            lastCall <= callVector;
            callCount <= callCount + 1;
        end
    end
endmodule

/* test/gsi_irq_ctrl_tb.sv */
// testbench of the gpio and source interrupt logic
`include "gsi_params.svh"

module gsi_irq_ctrl_tb;
    timeunit 1ns;
    timeprecision 1ps;
    // ------------------------------------------------
    // signals and instances
    // ------------------------------------------------
    logic        mclk = 1'b0, reset_n = 1'b0, wakePin = 1'b0;
    logic [11:0] s_axi_awaddr = 12'h000, s_axi_araddr = 12'h000;
    logic [31:0] s_axi_wdata = 32'h0000_0000, s_axi_rdata;
    logic [3:0]  s_axi_wstrb = 4'h1, instrLen = 4'h1;
    logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    logic [1:0]  s_axi_bresp, s_axi_rresp;
    logic [7:0]  port0Pins = 8'h00, port1Pins = 8'hFF, irqVector, callVector, lastCall;
    logic        instrLastClk, irqValid, callStrobe;
    logic [4:0]  src = 5'h00;
    int          callCount, expCalls = 0, n_fail = 0, checked = 0, cyc = 0;
    int          lv [5] = '{1, 2, 3, 4, 3};

    gsi_irq_ctrl i_dut
    (
        .mclk, .reset_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .port0Pins, .port1Pins, .wakePin, .timer128Event(src[0]), .timer1024Event(src[1]),
        .ep0RxAccepted(src[2]), .ep1TxAcked(src[3]), .ep0TxAcked(src[4]), .instrLastClk,
        .irqValid, .irqVector, .callStrobe, .callVector
    );
    gsi_core_model i_core
    (
        .mclk, .reset_n, .instrLen, .instrLastClk, .callStrobe, .callVector, .lastCall, .callCount
    );

    initial
    begin
        forever #10 mclk = ~mclk;
    end

    always @(posedge mclk)
    begin
        cyc <= cyc + 1;
        if (cyc == 20000)
        begin
            n_fail++;
            end_sim();
        end
    end
    // ------------------------------------------------
    // tasks
    // ------------------------------------------------
    task automatic end_sim();
        $display("checked %0d n_fail %0d", checked, n_fail);
        if (n_fail == 0 && checked > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic cmp(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp)
        begin
            n_fail++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
        logic aw, w;
        aw = 1'b0;
        w = 1'b0;
        @(posedge mclk);
        s_axi_awaddr <= {a[9:0], 2'b00};
        s_axi_awvalid <= 1'b1;
        s_axi_wdata <= d;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge mclk);
            aw |= s_axi_awready;
            w |= s_axi_wready;
            if (aw) s_axi_awvalid <= 1'b0;
            if (w) s_axi_wvalid <= 1'b0;
        end
        while (!(aw && w));
        while (!s_axi_bvalid) @(posedge mclk);
        s_axi_bready <= 1'b0;
        cmp(32'(s_axi_bresp), 32'(er));
    endtask

    task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
        @(posedge mclk);
        s_axi_araddr <= {a[9:0], 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge mclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'b0;
        while (!s_axi_rvalid) @(posedge mclk);
        s_axi_rready <= 1'b0;
        cmp(s_axi_rdata, ed);
        cmp(32'(s_axi_rresp), 32'(er));
    endtask

    task automatic pulse(input logic [4:0] s);
        @(posedge mclk);
        src <= s;
        @(posedge mclk);
        src <= 5'h00;
    endtask

    task automatic pins(input logic [7:0] p0, input logic [7:0] p1, input logic w);
        @(posedge mclk);
        port0Pins <= p0;
        port1Pins <= p1;
        wakePin <= w;
        repeat (4) @(posedge mclk);
    endtask

    task automatic waitCall(input logic [7:0] v);
        expCalls++;
        while (callCount < expCalls) @(posedge mclk);
        cmp(32'(lastCall), 32'(v));
    endtask
    // ------------------------------------------------
    // tests
    // ------------------------------------------------
    initial
    begin
        repeat (3) @(posedge mclk);
        reset_n <= 1'b1;
        rd(`GSI_OFF_GIEN, 32'h0000_0000, `GSI_RESP_OKAY);
        rd(`GSI_OFF_PEND, 32'h0000_0000, `GSI_RESP_OKAY);
        rd(`GSI_OFF_P0_IEN, 32'h0000_0000, `GSI_RESP_SLVERR);
        rd(`GSI_OFF_P1_IEN, 32'h0000_0000, `GSI_RESP_SLVERR);
        wr(12'h100, 32'h0000_00FF, `GSI_RESP_SLVERR);
        rd(12'h100, 32'h0000_0000, `GSI_RESP_SLVERR);
        wr(`GSI_OFF_GIEN, 32'h0000_00FF, `GSI_RESP_OKAY);
        rd(`GSI_OFF_GIEN, 32'h0000_00DE, `GSI_RESP_OKAY);
        // four sources at levels 1 to 4 at once, served highest first by a slow core
        instrLen <= 4'h7;
        wr(`GSI_OFF_GIEN, 32'h0000_0000, `GSI_RESP_OKAY);
        pulse(5'h0F);
        wr(`GSI_OFF_GIEN, 32'h0000_001E, `GSI_RESP_OKAY);
        for (int k = 1; k < 5; k++)
        begin
            waitCall(8'(2 * k));
            wr(`GSI_OFF_GIEN, 32'h0000_001E, `GSI_RESP_OKAY);
        end
        // each timer and endpoint source masked by its own bit, then served
        instrLen <= 4'h1;
        for (int j = 0; j < 5; j++)
        begin
            wr(`GSI_OFF_GIEN, 32'h0000_00DE & ~(32'h0000_0001 << lv[j]), `GSI_RESP_OKAY);
            pulse(5'h01 << j);
            rd(`GSI_OFF_VECT, 32'h0000_0000, `GSI_RESP_OKAY);
            rd(`GSI_OFF_PEND, 32'h0000_0001 << lv[j], `GSI_RESP_OKAY);
            wr(`GSI_OFF_GIEN, 32'h0000_0001 << lv[j], `GSI_RESP_OKAY);
            waitCall(8'(2 * lv[j]));
            rd(`GSI_OFF_PEND, 32'h0000_0000, `GSI_RESP_OKAY);
            rd(`GSI_OFF_GIEN, 32'h0000_0000, `GSI_RESP_OKAY);
        end
        // port pins
        wr(`GSI_OFF_POL0, 32'h0000_0003, `GSI_RESP_OKAY);
        wr(`GSI_OFF_P0_IEN, 32'h0000_0003, `GSI_RESP_OKAY);
        wr(`GSI_OFF_GIEN, 32'h0000_0040, `GSI_RESP_OKAY);
        pins(8'h01, 8'hFF, 1'b0);
        waitCall(8'h0C);
        rd(`GSI_OFF_GIEN, 32'h0000_0000, `GSI_RESP_OKAY);
        rd(`GSI_OFF_PINS, 32'h0000_FF01, `GSI_RESP_OKAY);
        wr(`GSI_OFF_GIEN, 32'h0000_0040, `GSI_RESP_OKAY);
        pins(8'h03, 8'hFF, 1'b0);
        rd(`GSI_OFF_PEND, 32'h0000_0000, `GSI_RESP_OKAY);
        cmp(32'(callCount), 32'(expCalls));
        pins(8'h00, 8'hFF, 1'b0);
        pins(8'h01, 8'hFF, 1'b0);
        waitCall(8'h0C);
        wr(`GSI_OFF_GIEN, 32'h0000_0040, `GSI_RESP_OKAY);
        wr(`GSI_OFF_P0_IEN, 32'h0000_0000, `GSI_RESP_OKAY);
        wr(`GSI_OFF_P0_IEN, 32'h0000_0001, `GSI_RESP_OKAY);
        waitCall(8'h0C);
        wr(`GSI_OFF_P0_IEN, 32'h0000_0000, `GSI_RESP_OKAY);
        wr(`GSI_OFF_POL1, 32'h0000_0000, `GSI_RESP_OKAY);
        wr(`GSI_OFF_P1_IEN, 32'h0000_0002, `GSI_RESP_OKAY);
        pins(8'h01, 8'hFE, 1'b0);
        rd(`GSI_OFF_PEND, 32'h0000_0000, `GSI_RESP_OKAY);
        pins(8'h01, 8'hFC, 1'b0);
        rd(`GSI_OFF_VECT, 32'h0000_0000, `GSI_RESP_OKAY);
        rd(`GSI_OFF_PEND, 32'h0000_0040, `GSI_RESP_OKAY);
        // halted core: vector seen, then software acknowledge
        instrLen <= 4'h0;
        wr(`GSI_OFF_GIEN, 32'h0000_0040, `GSI_RESP_OKAY);
        rd(`GSI_OFF_VECT, 32'h0000_010C, `GSI_RESP_OKAY);
        wr(`GSI_OFF_ACK, 32'h0000_0001, `GSI_RESP_OKAY);
        waitCall(8'h0C);
        instrLen <= 4'h1;
        // only wake-up enabled, rising wake pin served at 0x0E
        wr(`GSI_OFF_GIEN, 32'h0000_0080, `GSI_RESP_OKAY);
        pins(8'h01, 8'hFC, 1'b1);
        waitCall(8'h0E);
        end_sim();
    end
endmodule
